// ### src/timer_pkg.sv
// constants shared by the split/capture timer and its tick generator
package timer_pkg;

   // ----------------------------------------
   // register indices on the plain port
   // ----------------------------------------
   localparam logic [2:0] ADDR_CONTROL = 3'h0;
   localparam logic [2:0] ADDR_COUNT_LOW = 3'h1;
   localparam logic [2:0] ADDR_COUNT_HIGH = 3'h2;
   localparam logic [2:0] ADDR_RELOAD_LOW = 3'h3;
   localparam logic [2:0] ADDR_RELOAD_HIGH = 3'h4;
   localparam logic [2:0] ADDR_CLOCK_CONTROL = 3'h5;

   // ----------------------------------------
   // timer_control_reg field positions
   // ----------------------------------------
   localparam int BIT_HIGH_FLAG = 7;
   localparam int BIT_LOW_FLAG = 6;
   localparam int BIT_LOW_FLAG_IE = 5;
   localparam int BIT_CAPTURE_ENABLE = 4;
   localparam int BIT_SPLIT_SELECT = 3;
   localparam int BIT_RUN_CONTROL = 2;
   localparam int BIT_CAPTURE_SOURCE = 1;
   localparam int BIT_EXT_CLOCK_SELECT = 0;

   // ----------------------------------------
   // clock_control_reg field positions
   // ----------------------------------------
   localparam int BIT_CAPTURE_FLAG = 7;
   localparam int BIT_HIGH_CLOCK_SELECT = 1;
   localparam int BIT_LOW_CLOCK_SELECT = 0;

   // ----------------------------------------
   // reset values and encodings
   // ----------------------------------------
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] BYTE_MAX = 8'hff;
   localparam logic [15:0] WORD_MAX = 16'hffff;
   localparam logic CAPTURE_SRC_SOF = 1'b0;
   localparam logic CAPTURE_SRC_LFO = 1'b1;

   // ----------------------------------------
   // prescaler counts
   // ----------------------------------------
   localparam int SYS_DIVIDE = 12;
   localparam int EXT_DIVIDE = 8;
   localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIVIDE - 1);
   localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIVIDE - 1);

   // ----------------------------------------
   // operating modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      MODE_IDLE = 3'b001,
      MODE_SPLIT = 3'b010,
      MODE_CAPTURE = 3'b100
   } timer_mode_t;

endpackage

// ### src/timer_ticks.sv
// prescaler making the system/12 and external/8 count ticks
`timescale 1ns/1ps
module timer_ticks
   import timer_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // external clock level, synchronous to clk
   input wire logic ext_clk,
   // one-cycle ticks
   output logic tick_sys12,
   output logic tick_ext8
);

   logic [3:0] sys_div_q;
   logic [2:0] ext_div_q;
   logic ext_prev_q;
   logic ext_rise;

   // ----------------------------------------
   // system clock divided by twelve
   // ----------------------------------------
   // free running so every half sees the same phase
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sys_div_q <= 4'h0;
      end else if (sys_div_q == SYS_DIV_LAST) begin
         sys_div_q <= 4'h0;
      end else begin
         sys_div_q <= sys_div_q + 4'h1;
      end
   end
   assign tick_sys12 = (sys_div_q == SYS_DIV_LAST);

   // ----------------------------------------
   // external clock divided by eight
   // ----------------------------------------
   // rising edges are counted; the source must not exceed clk/2
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ext_prev_q <= 1'b0;
         ext_div_q <= 3'h0;
      end else begin
         ext_prev_q <= ext_clk;
         if (ext_rise) begin
            ext_div_q <= ext_div_q + 3'h1;
         end
      end
   end
   assign ext_rise = ext_clk & ~ext_prev_q;
   assign tick_ext8 = ext_rise & (ext_div_q == EXT_DIV_LAST);

endmodule

// ### src/split_capture_timer.sv
// sixteen-bit timer with split auto-reload and capture modes
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

// Behaviour
// RULE1: with split select set and capture enable clear, the timer runs as two independent 8-bit auto-reload halves.
// RULE2: in split mode reload_low feeds the low half and reload_high feeds the high half.
// RULE3: in split mode run control gates only the high half, the low half always counts.
// RULE4: each half counts on the system clock when its clock select is 1, else on system/12 or external/8.
// RULE5: a half rolling from 0xff to 0x00 sets its own overflow flag.
// RULE6: with the timer interrupt enabled and the low-flag enable clear, only the high flag requests an interrupt; the code also lets the capture flag request it.
// RULE7: with the timer interrupt enabled and the low-flag enable (control bit 5) set, either flag requests it.
// RULE8: overflow flags are never cleared by hardware; software clears them and checks both to find the source.
// RULE9: capture enable selects capture mode, whose event is a start-of-frame or a low-frequency oscillator fall.
// RULE10: in capture mode with split off the count runs as one 16-bit counter wrapping 0xffff to 0x0000.
// RULE11: each capture event copies the whole 16-bit count into the two reload registers.
// RULE12: in capture mode each capture event requests a timer interrupt when that interrupt is enabled.
// RULE13: a split half loads its reload value in the very clock in which it rolls over from its maximum.
// RULE14: capture source select 0 picks start-of-frame and 1 picks the oscillator falling edge.
module split_capture_timer
   import timer_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // clock and event sources
   input wire logic ext_clk,
   input wire logic sof_event,
   input wire logic low_frequency_oscillator,
   // interrupt path
   input wire logic timer_int_enable,
   output logic timer_irq
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [7:0] count_low_q, count_low_d;
   logic [7:0] count_high_q, count_high_d;
   logic [7:0] reload_low_q, reload_low_d;
   logic [7:0] reload_high_q, reload_high_d;
   logic high_overflow_flag_q, high_overflow_flag_d;
   logic low_overflow_flag_q, low_overflow_flag_d;
   logic capture_flag_q, capture_flag_d;
   logic low_flag_interrupt_enable_q;
   logic capture_enable_q;
   logic split_select_q;
   logic run_control_q;
   logic capture_source_select_q;
   logic external_clock_select_q;
   logic high_clock_select_q;
   logic low_clock_select_q;
   logic [7:0] rdata_q;
   logic lfo_prev_q;
   logic tick_sys12;
   logic tick_ext8;
   logic tick_low;
   logic tick_high;
   logic step_low;
   logic step_high;
   logic step_word;
   logic wrap_low;
   logic wrap_high;
   logic lfo_fall;
   logic capture_hit;
   logic [15:0] word_next;
   logic wr_control;
   logic wr_clock;
   timer_mode_t mode;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // picks the count tick of one half from its clock select bits
   function automatic logic half_tick(input logic sys_sel, input logic ext_sel,
                                      input logic t12, input logic te8);
      logic t;
      t = 1'b1;
      if (!sys_sel) begin
         t = ext_sel ? te8 : t12;
      end
      return t;
   endfunction

   // ----------------------------------------
   // prescaler
   // ----------------------------------------
   timer_ticks u_ticks (
      .clk(clk),
      .sys_rst(sys_rst),
      .ext_clk(ext_clk),
      .tick_sys12(tick_sys12),
      .tick_ext8(tick_ext8)
   );

   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   // capture takes precedence; split alone gives the 8-bit halves
   always_comb begin
      mode = MODE_IDLE;
      if (capture_enable_q) begin
         // RULE9 capture mode select
         mode = MODE_CAPTURE;
      end else if (split_select_q) begin
         // RULE1 split halves
         mode = MODE_SPLIT;
      end
   end

   // ----------------------------------------
   // count enables
   // ----------------------------------------
   // RULE4 per-half clock source
   assign tick_low = half_tick(low_clock_select_q, external_clock_select_q, tick_sys12, tick_ext8);
   assign tick_high = half_tick(high_clock_select_q, external_clock_select_q, tick_sys12, tick_ext8);

   // RULE3 low half free, high half gated
   assign step_low = (mode == MODE_SPLIT) & tick_low;
   assign step_high = (mode == MODE_SPLIT) & run_control_q & tick_high;
   // the 16-bit capture count uses the low clock select and run control
   assign step_word = (mode == MODE_CAPTURE) & run_control_q & tick_low;

   // RULE5 rollover detect per half
   assign wrap_low = step_low & (count_low_q == BYTE_MAX);
   assign wrap_high = step_high & (count_high_q == BYTE_MAX);

   // RULE10 16-bit up count, wraps naturally
   assign word_next = {count_high_q, count_low_q} + 16'h0001;

   // ----------------------------------------
   // capture event
   // ----------------------------------------
   // inputs are synchronous, so a plain previous-value edge detect is enough
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lfo_prev_q <= 1'b0;
      end else begin
         lfo_prev_q <= low_frequency_oscillator;
      end
   end
   assign lfo_fall = lfo_prev_q & ~low_frequency_oscillator;

   // RULE14 source encoding
   assign capture_hit = (mode == MODE_CAPTURE) &
      ((capture_source_select_q == CAPTURE_SRC_LFO) ? lfo_fall : sof_event);

   // ----------------------------------------
   // register write decode
   // ----------------------------------------
   assign wr_control = reg_wr & (reg_addr == ADDR_CONTROL);
   assign wr_clock = reg_wr & (reg_addr == ADDR_CLOCK_CONTROL);

   // ----------------------------------------
   // control bits
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         low_flag_interrupt_enable_q <= 1'b0;
         capture_enable_q <= 1'b0;
         split_select_q <= 1'b0;
         run_control_q <= 1'b0;
         capture_source_select_q <= 1'b0;
         external_clock_select_q <= 1'b0;
      end else if (wr_control) begin
         low_flag_interrupt_enable_q <= reg_wdata[BIT_LOW_FLAG_IE];
         capture_enable_q <= reg_wdata[BIT_CAPTURE_ENABLE];
         split_select_q <= reg_wdata[BIT_SPLIT_SELECT];
         run_control_q <= reg_wdata[BIT_RUN_CONTROL];
         capture_source_select_q <= reg_wdata[BIT_CAPTURE_SOURCE];
         external_clock_select_q <= reg_wdata[BIT_EXT_CLOCK_SELECT];
      end
   end

   // clock select bits
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         high_clock_select_q <= 1'b0;
         low_clock_select_q <= 1'b0;
      end else if (wr_clock) begin
         high_clock_select_q <= reg_wdata[BIT_HIGH_CLOCK_SELECT];
         low_clock_select_q <= reg_wdata[BIT_LOW_CLOCK_SELECT];
      end
   end

   // ----------------------------------------
   // flags
   // ----------------------------------------
   // software write comes first, a hardware set in the same cycle wins
   always_comb begin
      high_overflow_flag_d = high_overflow_flag_q;
      low_overflow_flag_d = low_overflow_flag_q;
      capture_flag_d = capture_flag_q;
      // RULE8 only software clears
      if (wr_control) begin
         high_overflow_flag_d = reg_wdata[BIT_HIGH_FLAG];
         low_overflow_flag_d = reg_wdata[BIT_LOW_FLAG];
      end
      if (wr_clock) begin
         capture_flag_d = reg_wdata[BIT_CAPTURE_FLAG];
      end
      // RULE5 overflow sets its flag
      if (wrap_high) begin
         high_overflow_flag_d = 1'b1;
      end
      if (wrap_low) begin
         low_overflow_flag_d = 1'b1;
      end
      // RULE12 capture raises its own flag
      if (capture_hit) begin
         capture_flag_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         high_overflow_flag_q <= 1'b0;
         low_overflow_flag_q <= 1'b0;
         capture_flag_q <= 1'b0;
      end else begin
         high_overflow_flag_q <= high_overflow_flag_d;
         low_overflow_flag_q <= low_overflow_flag_d;
         capture_flag_q <= capture_flag_d;
      end
   end

   // ----------------------------------------
   // counters
   // ----------------------------------------
   // a software write to a count byte wins over the count step
   always_comb begin
      count_low_d = count_low_q;
      count_high_d = count_high_q;
      if (step_word) begin
         count_low_d = word_next[7:0];
         count_high_d = word_next[15:8];
      end
      if (step_low) begin
         // RULE13 reload on the rollover clock
         // RULE2 low half reloads from reload_low
         count_low_d = wrap_low ? reload_low_q : count_low_q + 8'h01;
      end
      if (step_high) begin
         // RULE13 reload on the rollover clock
         // RULE2 high half reloads from reload_high
         count_high_d = wrap_high ? reload_high_q : count_high_q + 8'h01;
      end
      if (reg_wr && reg_addr == ADDR_COUNT_LOW) begin
         count_low_d = reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_COUNT_HIGH) begin
         count_high_d = reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_low_q <= RESET_BYTE;
         count_high_q <= RESET_BYTE;
      end else begin
         count_low_q <= count_low_d;
         count_high_q <= count_high_d;
      end
   end

   // ----------------------------------------
   // reload registers
   // ----------------------------------------
   // a capture wins over a software write so no event value is lost
   always_comb begin
      reload_low_d = reload_low_q;
      reload_high_d = reload_high_q;
      if (reg_wr && reg_addr == ADDR_RELOAD_LOW) begin
         reload_low_d = reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_RELOAD_HIGH) begin
         reload_high_d = reg_wdata;
      end
      // RULE11 latch both bytes together
      if (capture_hit) begin
         reload_low_d = count_low_q;
         reload_high_d = count_high_q;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reload_low_q <= RESET_BYTE;
         reload_high_q <= RESET_BYTE;
      end else begin
         reload_low_q <= reload_low_d;
         reload_high_q <= reload_high_d;
      end
   end

   // ----------------------------------------
   // interrupt request
   // ----------------------------------------
   // level request, held while an enabled flag stays set
   // RULE6 high flag always counts
   // RULE7 low flag counts when enabled
   // RULE12 capture flag requests too
   assign timer_irq = timer_int_enable &
      (high_overflow_flag_q | (low_flag_interrupt_enable_q & low_overflow_flag_q) | capture_flag_q);

   // ----------------------------------------
   // read port
   // ----------------------------------------
   // data stands for exactly one cycle after the read strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_q <= RESET_BYTE;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_CONTROL: begin
               rdata_q <= {high_overflow_flag_q, low_overflow_flag_q, low_flag_interrupt_enable_q,
                  capture_enable_q, split_select_q, run_control_q, capture_source_select_q,
                  external_clock_select_q};
            end
            ADDR_COUNT_LOW: begin
               rdata_q <= count_low_q;
            end
            ADDR_COUNT_HIGH: begin
               rdata_q <= count_high_q;
            end
            ADDR_RELOAD_LOW: begin
               rdata_q <= reload_low_q;
            end
            ADDR_RELOAD_HIGH: begin
               rdata_q <= reload_high_q;
            end
            ADDR_CLOCK_CONTROL: begin
               rdata_q <= {capture_flag_q, 5'h00, high_clock_select_q, low_clock_select_q};
            end
            default: begin
               rdata_q <= RESET_BYTE;
            end
         endcase
      end else begin
         rdata_q <= RESET_BYTE;
      end
   end
   assign reg_rdata = rdata_q;

endmodule

// ### tb/timer_props.sv
// port-level assertion checker for the split/capture timer
`timescale 1ns/1ps
module timer_props
   import timer_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // sources and interrupt
   input wire logic ext_clk,
   input wire logic sof_event,
   input wire logic low_frequency_oscillator,
   input wire logic timer_int_enable,
   input wire logic timer_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   // ----------------------------------------
   // shadow of the software control bits
   // ----------------------------------------
   logic [7:0] ctl_q;
   logic lfo_q;

   // mode bits change only by software writes, so a write shadow is exact
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctl_q <= 8'h00;
         lfo_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == ADDR_CONTROL) begin
            ctl_q <= reg_wdata;
         end
         lfo_q <= low_frequency_oscillator;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   // enable gates request
   chk_irq_gate: assert property (!timer_int_enable |-> !timer_irq)
      else $error("interrupt raised while disabled");
   chk_flag_sticky: assert property (timer_irq && timer_int_enable &&
      !(reg_wr && (reg_addr == ADDR_CONTROL || reg_addr == ADDR_CLOCK_CONTROL)) |=> timer_irq || !timer_int_enable)
      else $error("interrupt dropped without software clear");
   chk_sof_capture: assert property (ctl_q[4] && !ctl_q[1] && sof_event && !reg_wr && timer_int_enable
      |=> timer_irq || !timer_int_enable)
      else $error("no interrupt after frame-start capture");
   chk_lfo_capture: assert property (ctl_q[4] && ctl_q[1] && lfo_q && !low_frequency_oscillator
      && !reg_wr && timer_int_enable |=> timer_irq || !timer_int_enable)
      else $error("no interrupt after oscillator fall capture");
   chk_idle_quiet: assert property (ctl_q[4:3] == 2'b00 && !timer_irq && !reg_wr
      && timer_int_enable |=> !timer_irq)
      else $error("interrupt without cause in idle mode");
   chk_ctl_readback: assert property (reg_wr && reg_addr == ADDR_CONTROL ##1 reg_rd &&
      reg_addr == ADDR_CONTROL |=> (reg_rdata & 8'h3f) == ($past(reg_wdata, 2) & 8'h3f))
      else $error("control bits do not read back");
   chk_low_ie_irq: assert property (reg_wr && reg_addr == ADDR_CONTROL && reg_wdata[6] && reg_wdata[5]
      && timer_int_enable |=> timer_irq || !timer_int_enable)
      else $error("low flag with its enable gives no interrupt");
   chk_high_irq: assert property (reg_wr && reg_addr == ADDR_CONTROL && reg_wdata[7]
      && timer_int_enable |=> ##[0:1] timer_irq || !timer_int_enable)
      else $error("high flag gives no interrupt");

   // main scenarios reached
   cover property (ctl_q[4] && sof_event);
   cover property (ctl_q[3] && !ctl_q[4] && timer_irq);
   cover property ($rose(timer_irq));
endmodule

bind split_capture_timer timer_props chk_u (
   .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk(ext_clk),
   .sof_event(sof_event), .low_frequency_oscillator(low_frequency_oscillator),
   .timer_int_enable(timer_int_enable), .timer_irq(timer_irq)
);

// ### tb/tb_top.sv
// self-checking bench for the split/capture timer
`timescale 1ns/1ps
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("unexpected at %0t: %h, want %h", $time, (got), (exp)); end end
module tb_top
   import timer_pkg::*;
;

   // ----------------------------------------
   // stimulus and bookkeeping
   // ----------------------------------------
   // clocks start low by their declaration so each keeps a single driving process
   logic clk = 1'b0;
   logic ext_clk = 1'b0;
   logic sys_rst, reg_wr, reg_rd, sof_event, low_frequency_oscillator;
   logic timer_int_enable, timer_irq, s;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, v, r, h, l, c;
   int error_cnt, checks;

   split_capture_timer dut_u (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk(ext_clk),
      .sof_event(sof_event), .low_frequency_oscillator(low_frequency_oscillator),
      .timer_int_enable(timer_int_enable), .timer_irq(timer_irq)
   );

   // 100 ns period; external clock toggles each cycle, so a rising edge every two
   always #50 clk = ~clk;
   always @(posedge clk) ext_clk <= ~ext_clk;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // expected count after n steps of an auto-reloading byte
   function automatic logic [7:0] steps(input logic [7:0] cnt, input logic [7:0] rl, input int n);
      for (int i = 0; i < n; i++) begin
         cnt = (cnt == BYTE_MAX) ? rl : cnt + 8'h01;
      end
      return cnt;
   endfunction

   task automatic idle(input int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask

   // strobes stay up on return so back-to-back calls never assign twice per step
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_rd <= 1'b0;
      reg_wr <= 1'b1;
      @(posedge clk);
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      #1;
      d = reg_rdata;
   endtask

   // one capture event: frame-start pulse or oscillator high-then-low
   task automatic ev(input logic lfo_src);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      if (lfo_src) low_frequency_oscillator <= 1'b1;
      else sof_event <= 1'b1;
      @(posedge clk);
      low_frequency_oscillator <= 1'b0;
      sof_event <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic print_verdict();
      if (error_cnt == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("unexpected at %0t: run timed out", $time);
      print_verdict();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      sys_rst = 1'b1; reg_addr = 3'h0; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
      sof_event = 1'b0; low_frequency_oscillator = 1'b0; timer_int_enable = 1'b0;
      error_cnt = 0;
      checks = 0;
      void'($urandom(32'hf9859173));
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      timer_int_enable <= 1'b1;
      wr(3'h6, 8'hff);
      for (int a = 0; a < 8; a++) begin
         rd(3'(a), v);
         `CHECK(v, 8'h00)
      end
      // low half reload; reloads kept low so rollovers stay far apart
      r = 8'($urandom) & 8'h7f;
      h = 8'($urandom) & 8'h7f;
      wr(ADDR_CLOCK_CONTROL, 8'h03);
      wr(ADDR_CONTROL, 8'h08);
      wr(ADDR_COUNT_HIGH, 8'h05);
      wr(ADDR_RELOAD_LOW, r);
      wr(ADDR_RELOAD_HIGH, h);
      wr(ADDR_COUNT_LOW, 8'hfe);
      idle(2);
      rd(ADDR_COUNT_LOW, v); `CHECK(v, steps(8'hfe, r, 2))
      rd(ADDR_COUNT_HIGH, v); `CHECK(v, 8'h05)
      rd(ADDR_CONTROL, v); `CHECK(v, 8'h48)
      `CHECK(timer_irq, 1'b0)
      wr(ADDR_CONTROL, 8'h68);
      rd(ADDR_CONTROL, v); `CHECK(timer_irq, 1'b1)
      wr(ADDR_CONTROL, 8'h0c);
      wr(ADDR_COUNT_HIGH, 8'hfe);
      idle(2);
      rd(ADDR_COUNT_HIGH, v); `CHECK(v, steps(8'hfe, h, 2))
      rd(ADDR_CONTROL, v); `CHECK(v, 8'h8c)
      `CHECK(timer_irq, 1'b1)
      // divided clocks: any 12 or 16 cycles hold exactly one tick
      for (int m = 0; m < 2; m++) begin
         l = 8'($urandom) & 8'h7f;
         wr(ADDR_CLOCK_CONTROL, 8'h00);
         wr(ADDR_CONTROL, 8'h88 | 8'(m));
         wr(ADDR_COUNT_LOW, l);
         idle(m ? EXT_DIVIDE * 2 : SYS_DIVIDE);
         rd(ADDR_COUNT_LOW, v); `CHECK(v, steps(l, 8'h00, 1))
      end
      // halves pick clocks apart: high on every cycle, low on system/12
      wr(ADDR_CLOCK_CONTROL, 8'h02);
      wr(ADDR_CONTROL, 8'h8c);
      wr(ADDR_COUNT_HIGH, 8'h10);
      wr(ADDR_COUNT_LOW, l);
      idle(SYS_DIVIDE);
      rd(ADDR_COUNT_LOW, v); `CHECK(v, steps(l, 8'h00, 1))
      rd(ADDR_COUNT_HIGH, v); `CHECK(v, steps(8'h10, h, SYS_DIVIDE + 2))
      wr(ADDR_CONTROL, 8'h10);
      wr(ADDR_COUNT_HIGH, 8'hff);
      wr(ADDR_COUNT_LOW, 8'hff);
      wr(ADDR_CONTROL, 8'h14);
      idle(SYS_DIVIDE);
      rd(ADDR_COUNT_LOW, v); `CHECK(v, 8'h00)
      rd(ADDR_COUNT_HIGH, v); `CHECK(v, 8'h00)
      rd(ADDR_CONTROL, v); `CHECK(v, 8'h14)
      // captures from both sources, wrong source first
      for (int i = 0; i < 4; i++) begin
         s = i[0];
         h = 8'($urandom);
         l = 8'($urandom);
         c = {3'b000, 1'b1, 2'b00, s, 1'b0};
         wr(ADDR_CONTROL, c);
         rd(ADDR_CONTROL, v); `CHECK(v, c)
         wr(ADDR_COUNT_HIGH, h);
         wr(ADDR_COUNT_LOW, l);
         wr(ADDR_RELOAD_HIGH, ~h);
         wr(ADDR_RELOAD_LOW, ~l);
         wr(ADDR_CLOCK_CONTROL, 8'h00);
         ev(~s);
         rd(ADDR_RELOAD_LOW, v); `CHECK(v, ~l)
         `CHECK(timer_irq, 1'b0)
         ev(s);
         rd(ADDR_RELOAD_HIGH, v); `CHECK(v, h)
         rd(ADDR_RELOAD_LOW, v); `CHECK(v, l)
         `CHECK(timer_irq, 1'b1)
         rd(ADDR_CLOCK_CONTROL, v); `CHECK(v, 8'h80)
      end
      timer_int_enable <= 1'b0;
      rd(ADDR_CONTROL, v); `CHECK(timer_irq, 1'b0)
      print_verdict();
   end
endmodule
